//--- hw/ldb_pkg.sv
// shared constants and types for the detect and brightness config block
package ldb_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CFG_LO = 8'h00;
  localparam logic [7:0] OFF_CFG_HI = 8'h04;
  localparam logic [7:0] OFF_FAULT = 8'h08;

  // field positions inside the 48-bit configuration word
  localparam int RED_OPEN_LSB = 0;
  localparam int GREEN_OPEN_LSB = 2;
  localparam int BLUE_OPEN_LSB = 4;
  localparam int SPARE_BIT = 6;
  localparam int READBACK_BIT = 7;
  localparam int RED_LEVEL_LSB = 8;
  localparam int GREEN_LEVEL_LSB = 16;
  localparam int BLUE_LEVEL_LSB = 24;
  localparam int GLOBAL_LSB = 32;
  localparam int REMOVAL_LSB = 35;
  localparam int RED_SHORT_LSB = 39;
  localparam int GREEN_SHORT_LSB = 42;
  localparam int BLUE_SHORT_LSB = 45;

  // reset values of the fields
  localparam logic [1:0] OPEN_RST = 2'h0;
  localparam logic [7:0] LEVEL_RST = 8'h7f;
  localparam logic [2:0] GLOBAL_RST = 3'h3;
  localparam logic [3:0] REMOVAL_RST = 4'h7;
  localparam logic [2:0] SHORT_RST = 3'h0;

  // threshold figures in millivolts
  localparam logic [11:0] OPEN_DROP_MV0 = 12'd200;
  localparam logic [11:0] OPEN_DROP_MV1 = 12'd500;
  localparam logic [11:0] OPEN_DROP_MV2 = 12'd900;
  localparam logic [11:0] OPEN_DROP_MV3 = 12'd1200;
  localparam logic [11:0] MV_0200 = 12'd200;
  localparam logic [11:0] MV_0400 = 12'd400;
  localparam logic [11:0] MV_0800 = 12'd800;
  localparam logic [11:0] MV_1000 = 12'd1000;
  localparam logic [11:0] MV_1200 = 12'd1200;
  localparam logic [11:0] MV_1400 = 12'd1400;
  localparam logic [11:0] MV_1600 = 12'd1600;
  localparam logic [11:0] MV_1800 = 12'd1800;
  localparam logic [11:0] MV_2000 = 12'd2000;
  localparam logic [11:0] MV_2400 = 12'd2400;
  localparam logic [11:0] MV_2800 = 12'd2800;

  // configuration word as named fields, msb first
  typedef struct packed {
    logic [2:0] blueShort;
    logic [2:0] greenShort;
    logic [2:0] redShort;
    logic [3:0] removal;
    logic [2:0] globalLevel;
    logic [7:0] blueLevel;
    logic [7:0] greenLevel;
    logic [7:0] redLevel;
    logic readback;
    logic spare;
    logic [1:0] blueOpen;
    logic [1:0] greenOpen;
    logic [1:0] redOpen;
  } ldb_cfg_s;

  localparam ldb_cfg_s CFG_RST = '{
    blueShort: SHORT_RST, greenShort: SHORT_RST, redShort: SHORT_RST,
    removal: REMOVAL_RST, globalLevel: GLOBAL_RST,
    blueLevel: LEVEL_RST, greenLevel: LEVEL_RST, redLevel: LEVEL_RST,
    readback: 1'b0, spare: 1'b0,
    blueOpen: OPEN_RST, greenOpen: OPEN_RST, redOpen: OPEN_RST};

  // decoded thresholds handed to the analog side
  typedef struct packed {
    logic [11:0] redOpenDrop;
    logic [11:0] greenOpenDrop;
    logic [11:0] blueOpenDrop;
    logic [11:0] redShortMv;
    logic [11:0] greenShortMv;
    logic [11:0] blueShortMv;
    logic [4:0] removalLevel;
  } ldb_thr_s;

endpackage

//--- hw/ldb_thr_decode.sv
// converts threshold and level codes into millivolts and level numbers
`timescale 1ns/1ns
module ldb_thr_decode
(
  // configuration in
  input wire ldb_pkg::ldb_cfg_s cfg,
  // decoded values out
  output ldb_pkg::ldb_thr_s thr
);

  // supply minus drop: only the drop is produced here
  function automatic logic [11:0] openDrop(input logic [1:0] code);
    unique case (code)
      2'h0: openDrop = ldb_pkg::OPEN_DROP_MV0;
      2'h1: openDrop = ldb_pkg::OPEN_DROP_MV1;
      2'h2: openDrop = ldb_pkg::OPEN_DROP_MV2;
      2'h3: openDrop = ldb_pkg::OPEN_DROP_MV3;
    endcase
  endfunction

  // red uses a finer upper scale than green and blue
  function automatic logic [11:0] shortMv(input logic [2:0] code,
                                          input logic isRed);
    unique case (code)
      3'h0: shortMv = ldb_pkg::MV_0200;
      3'h1: shortMv = ldb_pkg::MV_0400;
      3'h2: shortMv = ldb_pkg::MV_0800;
      3'h3: shortMv = isRed ? ldb_pkg::MV_1000 : ldb_pkg::MV_1200;
      3'h4: shortMv = isRed ? ldb_pkg::MV_1200 : ldb_pkg::MV_1600;
      3'h5: shortMv = isRed ? ldb_pkg::MV_1400 : ldb_pkg::MV_2000;
      3'h6: shortMv = isRed ? ldb_pkg::MV_1600 : ldb_pkg::MV_2400;
      3'h7: shortMv = isRed ? ldb_pkg::MV_1800 : ldb_pkg::MV_2800;
    endcase
  endfunction

  always_comb
  begin
    thr.redOpenDrop = openDrop(cfg.redOpen);
    thr.greenOpenDrop = openDrop(cfg.greenOpen);
    thr.blueOpenDrop = openDrop(cfg.blueOpen);
    thr.redShortMv = shortMv(cfg.redShort, 1'b1);
    thr.greenShortMv = shortMv(cfg.greenShort, 1'b0);
    thr.blueShortMv = shortMv(cfg.blueShort, 1'b0);
    // code n means level n plus one
    thr.removalLevel = {1'b0, cfg.removal} + 5'd1;
  end

endmodule // ldb_thr_decode

//--- hw/ldb_config.sv
// apb register bank holding the led detect and brightness configuration
`timescale 1ns/1ns
module ldb_config
#(
  parameter int ADDR_W = 8
)
(
  // clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // detector results from the analog side
  input wire logic [2:0] openLoadDetect,
  input wire logic [2:0] shortDetect,
  // configuration fields
  output logic [1:0] redOpenThreshold,
  output logic [1:0] greenOpenThreshold,
  output logic [1:0] blueOpenThreshold,
  output logic faultReadbackEnable,
  output logic [7:0] redColorLevel,
  output logic [7:0] greenColorLevel,
  output logic [7:0] blueColorLevel,
  output logic [2:0] globalBrightness,
  output logic [3:0] shortRemovalLevel,
  output logic [2:0] redShortThreshold,
  output logic [2:0] greenShortThreshold,
  output logic [2:0] blueShortThreshold,
  // decoded thresholds
  output ldb_pkg::ldb_thr_s decoded
);

  ldb_pkg::ldb_cfg_s cfg_r;
  ldb_pkg::ldb_thr_s thrNxt;
  logic [5:0] fault_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [7:0] offset;
  logic accessPhase;
  logic accessDone;
  logic mapped;
  logic [31:0] readNxt;

  // byte-lane merge used by both halves of the configuration word
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    mergeBytes = res;
  endfunction

  assign offset = paddr[7:0];
  assign accessPhase = psel && penable;
  // the edge at which the master samples pready high ends the transfer
  assign accessDone = accessPhase && pready_r;

  always_comb
  begin
    mapped = 1'b1;
    readNxt = 32'h0000_0000;
    unique case (offset)
      ldb_pkg::OFF_CFG_LO: readNxt = cfg_r[31:0];
      ldb_pkg::OFF_CFG_HI: readNxt = {16'h0000, cfg_r[47:32]};
      ldb_pkg::OFF_FAULT: readNxt = {26'h000_0000, fault_r};
      default: mapped = 1'b0;
    endcase
  end

  // answer one cycle into the access phase; stall while ce is low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (accessPhase && !pready_r)
      begin
        pready_r <= 1'b1;
        pslverr_r <= !mapped;
        prdata_r <= (mapped && !pwrite) ? readNxt : 32'h0000_0000;
      end
      else
      begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  // configuration word: written only at the completing edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_r <= ldb_pkg::CFG_RST;
    end
    else if (ce && accessDone && pwrite)
    begin
      if (offset == ldb_pkg::OFF_CFG_LO)
      begin
        cfg_r[31:0] <= mergeBytes(cfg_r[31:0], pwdata, pstrb);
      end
      else if (offset == ldb_pkg::OFF_CFG_HI)
      begin
        // upper two lanes have no storage and are dropped
        cfg_r[47:32] <= 16'(mergeBytes({16'h0000, cfg_r[47:32]}, pwdata,
                                       {2'b00, pstrb[1:0]}));
      end
    end
  end

  // detector results are visible only while readback is enabled
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_r <= 6'h00;
    end
    else if (ce)
    begin
      fault_r <= cfg_r.readback ? {shortDetect, openLoadDetect}
                                : 6'h00;
    end
  end

  ldb_thr_decode u_decode
  (
    .cfg(cfg_r),
    .thr(thrNxt)
  );

  // field outputs registered so the analog side sees clean levels
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      redOpenThreshold <= ldb_pkg::OPEN_RST;
      greenOpenThreshold <= ldb_pkg::OPEN_RST;
      blueOpenThreshold <= ldb_pkg::OPEN_RST;
      faultReadbackEnable <= 1'b0;
      redColorLevel <= ldb_pkg::LEVEL_RST;
      greenColorLevel <= ldb_pkg::LEVEL_RST;
      blueColorLevel <= ldb_pkg::LEVEL_RST;
      globalBrightness <= ldb_pkg::GLOBAL_RST;
      shortRemovalLevel <= ldb_pkg::REMOVAL_RST;
      redShortThreshold <= ldb_pkg::SHORT_RST;
      greenShortThreshold <= ldb_pkg::SHORT_RST;
      blueShortThreshold <= ldb_pkg::SHORT_RST;
      decoded <= '0;
    end
    else if (ce)
    begin
      redOpenThreshold <= cfg_r.redOpen;
      greenOpenThreshold <= cfg_r.greenOpen;
      blueOpenThreshold <= cfg_r.blueOpen;
      faultReadbackEnable <= cfg_r.readback;
      redColorLevel <= cfg_r.redLevel;
      greenColorLevel <= cfg_r.greenLevel;
      blueColorLevel <= cfg_r.blueLevel;
      globalBrightness <= cfg_r.globalLevel;
      shortRemovalLevel <= cfg_r.removal;
      redShortThreshold <= cfg_r.redShort;
      greenShortThreshold <= cfg_r.greenShort;
      blueShortThreshold <= cfg_r.blueShort;
      decoded <= thrNxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule // ldb_config

//--- sim/ldb_config_assertions.sv
// bound checker for the detect and brightness config bank
`timescale 1ns/1ns
module ldb_config_assertions
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // configuration fields
  input wire logic [1:0] redOpenThreshold,
  input wire logic [1:0] greenOpenThreshold,
  input wire logic [1:0] blueOpenThreshold,
  input wire logic faultReadbackEnable,
  input wire logic [7:0] redColorLevel,
  input wire logic [7:0] greenColorLevel,
  input wire logic [7:0] blueColorLevel,
  input wire logic [2:0] globalBrightness,
  input wire logic [3:0] shortRemovalLevel,
  input wire logic [2:0] redShortThreshold,
  input wire logic [2:0] greenShortThreshold,
  input wire logic [2:0] blueShortThreshold
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic done = psel && penable && pready;
  wire logic wrLo = done && pwrite && paddr == 8'h00 && pstrb == 4'hf;
  wire logic wrHi = done && pwrite && paddr == 8'h04 && pstrb == 4'hf;
  // fields follow the stored word one cycle after the completing edge
  a_open_codes: assert property (wrLo |-> ##2
    {blueOpenThreshold, greenOpenThreshold, redOpenThreshold}
    == $past(pwdata[5:0], 2)) else $error("open codes");
  a_readback_bit: assert property (wrLo |-> ##2
    faultReadbackEnable == $past(pwdata[7], 2)) else $error("readback");
  a_color_levels: assert property (wrLo |-> ##2
    {blueColorLevel, greenColorLevel, redColorLevel}
    == $past(pwdata[31:8], 2)) else $error("colour levels");
  a_global_level: assert property (wrHi |-> ##2
    globalBrightness == $past(pwdata[2:0], 2)) else $error("global");
  a_removal_code: assert property (wrHi |-> ##2
    shortRemovalLevel == $past(pwdata[6:3], 2)) else $error("removal");
  a_short_codes: assert property (wrHi |-> ##2
    {blueShortThreshold, greenShortThreshold, redShortThreshold}
    == $past(pwdata[15:7], 2)) else $error("short codes");
  a_read_hi: assert property (done && !pwrite
    && paddr == 8'h04 |-> prdata == {16'h0000, blueShortThreshold,
    greenShortThreshold, redShortThreshold, shortRemovalLevel,
    globalBrightness}) else $error("high readback");
  a_read_lo: assert property (done && !pwrite
    && paddr == 8'h00 |-> {prdata[31:7], prdata[5:0]} == {blueColorLevel,
    greenColorLevel, redColorLevel, faultReadbackEnable, blueOpenThreshold,
    greenOpenThreshold, redOpenThreshold}) else $error("low readback");
endmodule // ldb_config_assertions

bind ldb_config ldb_config_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk,
  .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .redOpenThreshold, .greenOpenThreshold, .blueOpenThreshold,
  .faultReadbackEnable, .redColorLevel, .greenColorLevel, .blueColorLevel,
  .globalBrightness, .shortRemovalLevel, .redShortThreshold,
  .greenShortThreshold, .blueShortThreshold);

//--- sim/ldb_config_tb.sv
// self-checking bench for the detect and brightness config bank
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module ldb_config_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic ce = 1'b1;
  longint t0;
  logic [2:0] openLoadDetect = 3'h0;
  logic [2:0] shortDetect = 3'h0;
  logic [31:0] prdata, rdat, w;
  logic pready, pslverr, rerr, faultReadbackEnable;
  logic [1:0] redOpenThreshold, greenOpenThreshold, blueOpenThreshold;
  logic [7:0] redColorLevel, greenColorLevel, blueColorLevel;
  logic [2:0] globalBrightness, redShortThreshold, greenShortThreshold;
  logic [2:0] blueShortThreshold;
  logic [3:0] shortRemovalLevel;
  logic [47:0] cfg;
  ldb_pkg::ldb_thr_s decoded;
  int err_count = 0;
  int n_tests = 0;
  logic [11:0] openMv [4] = '{12'h0c8, 12'h1f4, 12'h384, 12'h4b0};
  logic [11:0] redMv [8] = '{12'h0c8, 12'h190, 12'h320, 12'h3e8, 12'h4b0,
    12'h578, 12'h640, 12'h708};
  logic [11:0] grnMv [8] = '{12'h0c8, 12'h190, 12'h320, 12'h4b0, 12'h640,
    12'h7d0, 12'h960, 12'haf0};
  // low bytes 00/55/aa/ff reach every open code and both bits 6 and 7
  logic [31:0] loWords [4] = '{32'h00ff7f00, 32'h12345655, 32'hfe0180aa,
    32'hffffffff};

  always #20 clk = ~clk;

  ldb_config u_dut (.clk, .sys_rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .openLoadDetect,
    .shortDetect, .redOpenThreshold, .greenOpenThreshold, .blueOpenThreshold,
    .faultReadbackEnable, .redColorLevel, .greenColorLevel, .blueColorLevel,
    .globalBrightness, .shortRemovalLevel, .redShortThreshold,
    .greenShortThreshold, .blueShortThreshold, .decoded);

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] a, input logic wr,
    input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 20)
    begin
      err_count++;
      $display("[FAIL] %0t no answer", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // ports are tied to the read data by the checker, so readback covers them
  task automatic chkCfg(input logic [47:0] c);
    xfer(8'h00, 1'b0, 32'h0);
    `CHK(rdat, c[31:0])
    xfer(8'h04, 1'b0, 32'h0);
    `CHK(rdat, {16'h0000, c[47:32]})
    `CHK(decoded.redOpenDrop, openMv[c[1:0]])
    `CHK(decoded.greenOpenDrop, openMv[c[3:2]])
    `CHK(decoded.blueOpenDrop, openMv[c[5:4]])
    `CHK(decoded.removalLevel, {1'b0, c[38:35]} + 5'h01)
    `CHK(decoded.redShortMv, redMv[c[41:39]])
    `CHK(decoded.greenShortMv, grnMv[c[44:42]])
    `CHK(decoded.blueShortMv, grnMv[c[47:45]])
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    cfg = {9'h000, 4'h7, 3'h3, 24'h7f7f7f, 8'h00};
    chkCfg(cfg);
    $display("reset values done");
    for (int i = 0; i < 4; i++)
    begin
      xfer(8'h00, 1'b1, loWords[i]);
      cfg[31:0] = loWords[i];
      chkCfg(cfg);
    end
    $display("low word done");
    for (int k = 0; k < 8; k++)
    begin
      w = {16'hffff, 3'(k), 3'(~k), 3'(k), 4'(2 * k + 1), 3'(7 - k)};
      xfer(8'h04, 1'b1, w);
      cfg[47:32] = w[15:0];
      chkCfg(cfg);
    end
    $display("high word done");
    openLoadDetect <= 3'h5;
    shortDetect <= 3'h2;
    xfer(8'h00, 1'b1, 32'h00000000);
    xfer(8'h08, 1'b0, 32'h0);
    `CHK(rdat, 32'h00000000)
    xfer(8'h00, 1'b1, 32'h00000080);
    xfer(8'h08, 1'b0, 32'h0);
    `CHK(rdat, 32'h00000015)
    $display("fault readback done");
    xfer(8'h0c, 1'b1, 32'hdeadbeef);
    `CHK(rerr, 1'b1)
    xfer(8'h00, 1'b0, 32'h0);
    `CHK(rdat, 32'h00000080)
    `CHK(rerr, 1'b0)
    $display("unmapped access done");
    // a byte strobe touches only its own lane
    pstrb <= 4'h2;
    xfer(8'h00, 1'b1, 32'h5a5a335a);
    pstrb <= 4'hf;
    xfer(8'h00, 1'b0, 32'h0);
    `CHK(rdat, 32'h00003380)
    // three edges with ce low in the access phase add three cycles
    t0 = $time;
    fork
      xfer(8'h04, 1'b0, 32'h0);
      begin
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    `CHK(($time - t0) / 40, 7)
    `CHK(rdat, {16'h0000, cfg[47:32]})
    $display("strobe and enable done");
    summarize();
  end

  initial
  begin
    #400000;
    err_count++;
    $display("[FAIL] %0t watchdog", $time);
    summarize();
  end
endmodule // ldb_config_tb
